// [ctp_defs.svh]
`ifndef CTP_DEFS_SVH
`define CTP_DEFS_SVH

// Character field positions
`define CTP_NUM_LSB      0
`define CTP_NUM_MSB      3
`define CTP_ZONE_LSB     4
`define CTP_ZONE_MSB     5
`define CTP_CHAR_W       6

// Character codes: space, and those with a printer function
`define CTP_CHAR_SPACE   6'h00
`define CTP_CHAR_CRLF    6'h13
`define CTP_CHAR_BELL    6'h23
`define CTP_CHAR_TAB     6'h2E
`define CTP_CHAR_FF      6'h3E

// Reset values
`define CTP_RST_CHAR     6'h00
`define CTP_RST_ONLINE   1'b1

`endif

// [ctp_pkg.sv]
package ctp_pkg;
    // Six-bit typewriter character: zone over numeric
    typedef struct packed {
        logic [1:0] zone;
        logic [3:0] num;
    } ctp_char_t;

    // Printer functions decoded from a character
    typedef struct packed {
        logic crlf;
        logic bell;
        logic tab;
        logic ffeed;
    } ctp_ctl_t;

    // Keyboard arming state
    typedef enum logic {
        CTP_KBD_IDLE,
        CTP_KBD_ARMED
    } ctp_kbd_t;
endpackage : ctp_pkg

// [ctp_stream_if.sv]
`timescale 1ns/10ps
interface ctp_stream_if #(
    parameter int W = 10
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input  ready);
    modport snk (input  valid, input  data, output ready);
endinterface : ctp_stream_if

// [ctp_pbuf.sv]
`timescale 1ns/10ps
// Two-entry print buffer; slot 0 is always the head so outputs come from flops
module ctp_pbuf (
    input  wire logic clk,    // Clock
    input  wire logic rst,    // Async reset, active high
    input  wire logic ce,     // Clock enable
    ctp_stream_if.snk in_s,   // Fill side
    ctp_stream_if.src out_s   // Drain side
);
    localparam int W = $bits(in_s.data);

    logic [W-1:0] d0_ff, d1_ff, nxt_d0, nxt_d1;
    logic         v0_ff, v1_ff, nxt_v0, nxt_v1;
    logic         rdy_ff;
    logic         push, pop;

    assign push = in_s.valid & rdy_ff;
    assign pop  = v0_ff & out_s.ready;

    // Next contents: pop shifts slot 1 forward, push fills the first free slot
    always_comb begin
        nxt_d0 = d0_ff;
        nxt_d1 = d1_ff;
        nxt_v0 = v0_ff;
        nxt_v1 = v1_ff;
        if (pop) begin
            nxt_d0 = d1_ff;
            nxt_v0 = v1_ff;
            nxt_v1 = 1'b0;
        end
        if (push) begin
            if (!nxt_v0) begin
                nxt_d0 = in_s.data;
                nxt_v0 = 1'b1;
            end else begin
                nxt_d1 = in_s.data;
                nxt_v1 = 1'b1;
            end
        end
    end

    // Ready is registered from the next fill level, so it drops in the very cycle the buffer becomes full
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            d0_ff  <= '0;
            d1_ff  <= '0;
            v0_ff  <= 1'b0;
            v1_ff  <= 1'b0;
            rdy_ff <= 1'b1;
        end else if (ce) begin
            d0_ff  <= nxt_d0;
            d1_ff  <= nxt_d1;
            v0_ff  <= nxt_v0;
            v1_ff  <= nxt_v1;
            rdy_ff <= ~nxt_v1;
        end
    end

    assign in_s.ready  = rdy_ff;
    assign out_s.valid = v0_ff;
    assign out_s.data  = d0_ff;
endmodule : ctp_pbuf

// [ctp_port.sv]
`timescale 1ns/10ps
`include "ctp_defs.svh"

module ctp_port #(
    parameter int REG_W = 4                       // Arithmetic register select width
) (
    input  wire logic                clk,             // 40 MHz clock
    input  wire logic                rst,             // Async reset, active high
    input  wire logic                ce,              // Clock enable
    input  wire logic                print_char_instr, // Print instruction strobe
    input  wire ctp_pkg::ctp_char_t  print_data,      // Character from memory
    output logic                     print_ready,     // Buffer can take a print
    input  wire logic                arm_keyboard_instr, // Arm instruction strobe
    input  wire logic                read_char_instr, // Read instruction strobe
    input  wire logic [REG_W-1:0]    read_reg,        // Destination register
    output logic                     read_valid,      // Read answer pulse
    output ctp_pkg::ctp_char_t       read_char,       // Read answer data
    output logic [REG_W-1:0]         read_dest,       // Read answer register
    input  wire logic                clr_done,        // Clear completion indicator
    input  wire logic                clr_req,         // Clear request indicator
    input  wire logic                clr_rel,         // Clear release indicator
    output logic                     done_ind,        // Completion indicator
    output logic                     req_ind,         // Input-request indicator
    output logic                     rel_ind,         // Input-done indicator
    output logic                     contingency_irq, // Any indicator set
    output logic                     prt_valid,       // Character to typewriter
    output ctp_pkg::ctp_char_t       prt_char,        // Character to print
    output ctp_pkg::ctp_ctl_t        prt_ctl,         // Decoded printer function
    input  wire logic                prt_ready,       // Typewriter takes character
    input  wire logic                prt_done,        // Print cycle finished pulse
    input  wire logic                key_strobe,      // Key pressed pulse
    input  wire ctp_pkg::ctp_char_t  key_char,        // Keyed character
    input  wire logic                req_btn,         // Input-request button
    input  wire logic                rel_btn,         // Input-done button
    input  wire logic                online_btn,      // On-line button
    input  wire logic                offline_btn,     // Off-line button
    output logic                     online,          // On-line lamp
    output logic                     kbd_armed,       // Keyboard-armed lamp
    output ctp_pkg::ctp_char_t       typewriter_char_buffer // Buffer register
);
    import ctp_pkg::*;

    localparam int PW = $bits(ctp_ctl_t) + `CTP_CHAR_W;

    ctp_char_t    tcb_ff;
    ctp_kbd_t     kbd_ff;
    logic         online_ff, done_ff, req_ff, rel_ff, irq_ff;
    logic         nxt_done, nxt_req, nxt_rel;
    logic         rd_valid_ff;
    ctp_char_t    rd_char_ff;
    logic [REG_W-1:0] rd_dest_ff;
    logic         print_accept, key_accept;
    ctp_ctl_t     ctl;

    ctp_stream_if #(.W(PW)) in_s ();
    ctp_stream_if #(.W(PW)) out_s ();

    // Function decode on the way in, so the typewriter sees it with the char
    always_comb begin
        ctl       = '0;
        ctl.crlf  = (print_data == `CTP_CHAR_CRLF);
        ctl.bell  = (print_data == `CTP_CHAR_BELL);
        ctl.tab   = (print_data == `CTP_CHAR_TAB);
        ctl.ffeed = (print_data == `CTP_CHAR_FF);
    end

    // A print is a push into the buffer; the caller waits on the typewriter only when both slots are full
    assign in_s.valid   = ce & print_char_instr;
    assign in_s.data    = {ctl, print_data};
    assign print_accept = in_s.valid & in_s.ready;
    assign out_s.ready  = prt_ready;

    // Key capture needs arming and on-line; a print in the same cycle wins
    assign key_accept = ce & key_strobe & online_ff & (kbd_ff == CTP_KBD_ARMED)
                        & ~print_accept;

    ctp_pbuf u_pbuf (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .in_s  (in_s.snk),
        .out_s (out_s.src)
    );

    // Character buffer: shared by print and keyboard
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tcb_ff <= `CTP_RST_CHAR;
        end else if (print_accept) begin
            tcb_ff <= print_data;
        end else if (key_accept) begin
            tcb_ff <= key_char;
        end
    end

    // Keyboard arming; a fresh arm beats a same-cycle disarm
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            kbd_ff <= CTP_KBD_IDLE;
        end else if (ce) begin
            case (kbd_ff)
                CTP_KBD_IDLE: begin
                    if (arm_keyboard_instr) begin
                        kbd_ff <= CTP_KBD_ARMED;
                    end
                end
                CTP_KBD_ARMED: begin
                    if (!arm_keyboard_instr && (key_accept || rel_btn)) begin
                        kbd_ff <= CTP_KBD_IDLE;
                    end
                end
                default: kbd_ff <= CTP_KBD_IDLE;
            endcase
        end
    end

    // On-line state; pressing both buttons at once changes nothing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            online_ff <= `CTP_RST_ONLINE;
        end else if (ce) begin
            if (!online_ff && online_btn && !offline_btn) begin
                online_ff <= 1'b1;
            end else if (online_ff && offline_btn && !online_btn) begin
                online_ff <= 1'b0;
            end
        end
    end

    // Sticky indicators: set beats clear so no event is lost
    always_comb begin
        nxt_done = (done_ff & ~clr_done) | prt_done | key_accept;
        nxt_req  = (req_ff & ~clr_req) | (req_btn & online_ff);
        nxt_rel  = (rel_ff & ~clr_rel) | rel_btn;
    end

    // Interrupt is registered from next values so it tracks the indicators
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_ff <= 1'b0;
            req_ff  <= 1'b0;
            rel_ff  <= 1'b0;
            irq_ff  <= 1'b0;
        end else if (ce) begin
            done_ff <= nxt_done;
            req_ff  <= nxt_req;
            rel_ff  <= nxt_rel;
            irq_ff  <= nxt_done | nxt_req | nxt_rel;
        end
    end

    // Read answer: one-cycle pulse with the buffer and destination
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_valid_ff <= 1'b0;
            rd_char_ff  <= `CTP_RST_CHAR;
            rd_dest_ff  <= '0;
        end else if (ce) begin
            rd_valid_ff <= read_char_instr;
            if (read_char_instr) begin
                rd_char_ff <= tcb_ff;
                rd_dest_ff <= read_reg;
            end
        end
    end

    assign print_ready            = in_s.ready;
    assign read_valid             = rd_valid_ff;
    assign read_char              = rd_char_ff;
    assign read_dest              = rd_dest_ff;
    assign done_ind               = done_ff;
    assign req_ind                = req_ff;
    assign rel_ind                = rel_ff;
    assign contingency_irq        = irq_ff;
    assign prt_valid              = out_s.valid;
    assign prt_char               = out_s.data[`CTP_CHAR_W-1:0];
    assign prt_ctl                = out_s.data[PW-1:`CTP_CHAR_W];
    assign online                 = online_ff;
    assign kbd_armed              = (kbd_ff == CTP_KBD_ARMED);
    assign typewriter_char_buffer = tcb_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_print_load;
        print_accept |=> tcb_ff == $past(print_data);
    endproperty
    a_print_load: assert property (p_print_load) else $error("print did not load buffer");

    property p_print_queued;
        print_accept && !prt_valid |=> prt_valid && prt_char == $past(print_data);
    endproperty
    a_print_queued: assert property (p_print_queued) else $error("print not launched");

    property p_done_set;
        ce && prt_done |=> done_ff && irq_ff;
    endproperty
    a_done_set: assert property (p_done_set) else $error("completion not flagged");

    property p_done_hold;
        done_ff && !clr_done |=> done_ff;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("completion dropped");

    property p_req;
        ce && req_btn && online_ff |=> req_ff && contingency_irq;
    endproperty
    a_req: assert property (p_req) else $error("request not flagged");

    property p_req_off;
        ce && req_btn && !online_ff && !req_ff |=> !req_ff;
    endproperty
    a_req_off: assert property (p_req_off) else $error("request acted off-line");

    property p_key;
        key_accept && !arm_keyboard_instr |=> !kbd_armed && done_ff
            && tcb_ff == $past(key_char);
    endproperty
    a_key: assert property (p_key) else $error("key capture wrong");

    // Only an empty queue proves the key itself started no print
    property p_key_quiet;
        key_accept && !prt_valid |=> !prt_valid;
    endproperty
    a_key_quiet: assert property (p_key_quiet) else $error("keyed char printed");

    property p_one_key;
        key_accept && !arm_keyboard_instr ##1 (!arm_keyboard_instr)[*2]
            |-> !key_accept;
    endproperty
    a_one_key: assert property (p_one_key) else $error("second key captured");

    property p_read;
        ce && read_char_instr |=> read_valid && read_char == $past(tcb_ff)
            && read_dest == $past(read_reg);
    endproperty
    a_read: assert property (p_read) else $error("read answer wrong");

    property p_rel;
        ce && rel_btn && !arm_keyboard_instr |=> rel_ff && !kbd_armed;
    endproperty
    a_rel: assert property (p_rel) else $error("release not handled");

    property p_set_wins;
        ce && prt_done && clr_done |=> done_ff;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

    property p_hold;
        !print_accept && !key_accept |=> $stable(tcb_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("buffer changed");

    property p_crlf;
        prt_valid && prt_char == `CTP_CHAR_CRLF |-> prt_ctl.crlf && !prt_ctl.tab;
    endproperty
    a_crlf: assert property (p_crlf) else $error("crlf decode wrong");

    property p_online;
        ce && online_btn && !offline_btn && !online_ff |=> online_ff;
    endproperty
    a_online: assert property (p_online) else $error("on-line ignored");

    c_print: cover property (print_accept ##[1:20] prt_done);
    c_key:   cover property (arm_keyboard_instr ##[1:20] key_accept);
    c_clash: cover property (ce && prt_done && clr_done);
    c_full:  cover property (!print_ready);
endmodule : ctp_port

// [ctp_tw_model.sv]
`timescale 1ns/10ps
// Behavioural typewriter: takes one character, then is busy for PRINT_CYC cycles
module ctp_tw_model #(
    parameter int PRINT_CYC = 5                   // Print time in clock cycles
) (
    input  wire logic               clk,          // Clock
    input  wire logic               rst,          // Async reset, active high
    input  wire logic               stall,        // Holds off acceptance
    input  wire logic               prt_valid,    // Character offered
    input  wire ctp_pkg::ctp_char_t prt_char,     // Character to print
    input  wire ctp_pkg::ctp_ctl_t  prt_ctl,      // Decoded printer function
    output logic                    prt_ready,    // Takes character
    output logic                    prt_done      // Print cycle finished
);
    import ctp_pkg::*;

    ctp_char_t got_char[$];
    ctp_ctl_t  got_ctl[$];
    int        busy;
    logic      take;

    assign take = prt_valid && prt_ready;

    // Ready only when idle, so a slow mechanism really backs up the buffer
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prt_ready <= 1'b0;
            prt_done  <= 1'b0;
            busy      <= 0;
        end else begin
            if (take) begin
                got_char.push_back(prt_char);
                got_ctl.push_back(prt_ctl);
                busy <= PRINT_CYC;
            end else if (busy != 0) begin
                busy <= busy - 1;
            end
            prt_done  <= !take && busy == 1;              // One pulse per character
            prt_ready <= !stall && !take && busy <= 1;
        end
    end
endmodule : ctp_tw_model

// [ctp_port_tb_top.sv]
`timescale 1ns/10ps
module ctp_port_tb_top;
    import ctp_pkg::*;

    localparam int PRINT_CYC = 5;
    localparam int LIMIT     = 3000;
    localparam int PRT = 0, ARM = 1, RD = 2, CDONE = 3, CREQ = 4, CREL = 5;
    localparam int KEY = 6, REQ = 7, REL = 8, ONB = 9, OFFB = 10;

    logic        clk, rst, stall, ce;
    logic [10:0] strb;                             // One bit per strobe input
    ctp_char_t   print_data, key_char, read_char, prt_char, typewriter_char_buffer;
    ctp_ctl_t    prt_ctl;
    logic [3:0]  read_reg, read_dest;
    logic        print_ready, read_valid, done_ind, req_ind, rel_ind, contingency_irq;
    logic        prt_valid, prt_ready, prt_done, online, kbd_armed;
    int          err_total = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    logic [5:0]  codes[6] = '{6'h00, 6'h13, 6'h23, 6'h2E, 6'h3E, 6'h03};
    logic [3:0]  ctls[6]  = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'h0};

    ctp_port i_dut (
        .clk(clk), .rst(rst), .ce(ce),
        .print_char_instr(strb[PRT]), .print_data(print_data), .print_ready(print_ready),
        .arm_keyboard_instr(strb[ARM]), .read_char_instr(strb[RD]), .read_reg(read_reg),
        .read_valid(read_valid), .read_char(read_char), .read_dest(read_dest),
        .clr_done(strb[CDONE]), .clr_req(strb[CREQ]), .clr_rel(strb[CREL]),
        .done_ind(done_ind), .req_ind(req_ind), .rel_ind(rel_ind),
        .contingency_irq(contingency_irq), .prt_valid(prt_valid), .prt_char(prt_char),
        .prt_ctl(prt_ctl), .prt_ready(prt_ready), .prt_done(prt_done),
        .key_strobe(strb[KEY]), .key_char(key_char), .req_btn(strb[REQ]),
        .rel_btn(strb[REL]), .online_btn(strb[ONB]), .offline_btn(strb[OFFB]),
        .online(online), .kbd_armed(kbd_armed),
        .typewriter_char_buffer(typewriter_char_buffer)
    );

    ctp_tw_model #(.PRINT_CYC(PRINT_CYC)) i_tw (
        .clk(clk), .rst(rst), .stall(stall), .prt_valid(prt_valid), .prt_char(prt_char),
        .prt_ctl(prt_ctl), .prt_ready(prt_ready), .prt_done(prt_done)
    );

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Hang guard: a stuck handshake still ends in a verdict
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            results();
        end
    end

    // Inputs always move 1 ns after the edge, away from sampling
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic pulse(input logic [10:0] m);
        strb = m;
        tick();
        strb = '0;
    endtask : pulse

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    // Bounded wait for the completion indicator
    task automatic wait_done();
        for (int i = 0; i < 50 && done_ind !== 1'b1; i++) tick();
    endtask : wait_done

    task automatic end_test(input string name);
        $display("test %s finished, mismatches so far %0d", name, err_total);
    endtask : end_test

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    initial begin
        rst = 1'b1;
        stall = 1'b0;
        ce = 1'b1;
        strb = '0;
        print_data = '0;
        key_char = '0;
        read_reg = '0;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        chk_val(typewriter_char_buffer, 8'h00);
        chk_bit(print_ready, 1'b1);
        chk_bit(online, 1'b1);
        chk_bit(contingency_irq, 1'b0);
        tick();
        end_test("reset");
        // Every printer function plus plain characters on either side of them
        for (int i = 0; i < 6; i++) begin
            print_data = codes[i];
            pulse(11'h001 << PRT);
            chk_val(typewriter_char_buffer, 8'(codes[i]));
            wait_done();
            chk_bit(contingency_irq, 1'b1);
            repeat (3) tick();
            chk_bit(done_ind, 1'b1);
            chk_val(i_tw.got_char.pop_front(), 8'(codes[i]));
            chk_val(i_tw.got_ctl.pop_front(), 8'(ctls[i]));
            pulse(11'h001 << CDONE);
            chk_bit(done_ind, 1'b0);
        end
        end_test("print codes");
        // Stalled typewriter: two back-to-back prints fill the buffer
        stall = 1'b1;
        tick();
        print_data = 6'h21;
        strb = 11'h001 << PRT;
        tick();
        print_data = 6'h22;
        tick();
        strb = '0;
        tick();
        chk_bit(print_ready, 1'b0);
        print_data = 6'h24;
        pulse(11'h001 << PRT);
        chk_val(typewriter_char_buffer, 8'h22);
        stall = 1'b0;
        for (int i = 0; i < 60 && i_tw.got_char.size() < 2; i++) tick();
        repeat (3 * PRINT_CYC) tick();
        chk_val(8'(i_tw.got_char.size()), 8'h02);
        chk_val(i_tw.got_char.pop_front(), 8'h21);
        chk_val(i_tw.got_char.pop_front(), 8'h22);
        chk_bit(print_ready, 1'b1);
        pulse(11'h001 << CDONE);
        end_test("buffer");
        // Keyboard: unarmed key ignored, armed key captured once
        key_char = 6'h15;
        pulse(11'h001 << KEY);
        chk_val(typewriter_char_buffer, 8'h22);
        chk_bit(done_ind, 1'b0);
        pulse(11'h001 << ARM);
        chk_bit(kbd_armed, 1'b1);
        pulse(11'h001 << KEY);
        chk_val(typewriter_char_buffer, 8'h15);
        chk_bit(kbd_armed, 1'b0);
        chk_bit(done_ind, 1'b1);
        chk_bit(prt_valid, 1'b0);
        key_char = 6'h16;
        pulse(11'h001 << KEY);
        chk_val(typewriter_char_buffer, 8'h15);
        pulse(11'h001 << CDONE);
        read_reg = 4'hA;
        pulse(11'h001 << RD);
        chk_bit(read_valid, 1'b1);
        chk_val(read_char, 8'h15);
        chk_val(read_dest, 8'h0A);
        tick();
        chk_bit(read_valid, 1'b0);
        chk_val(8'(i_tw.got_char.size()), 8'h00);
        end_test("keyboard");
        // Release button disarms and raises its own indicator
        pulse(11'h001 << ARM);
        pulse(11'h001 << REL);
        chk_bit(rel_ind, 1'b1);
        chk_bit(kbd_armed, 1'b0);
        chk_bit(contingency_irq, 1'b1);
        pulse(11'h001 << CREL);
        chk_bit(rel_ind, 1'b0);
        end_test("release");
        // Request button, set against clear, and on-line switching
        pulse((11'h001 << REQ) | (11'h001 << CREQ));
        chk_bit(req_ind, 1'b1);
        pulse(11'h001 << CREQ);
        chk_bit(req_ind, 1'b0);
        pulse(11'h001 << OFFB);
        chk_bit(online, 1'b0);
        pulse(11'h001 << OFFB);
        chk_bit(online, 1'b0);
        pulse(11'h001 << REQ);
        chk_bit(req_ind, 1'b0);
        pulse(11'h001 << ONB);
        chk_bit(online, 1'b1);
        pulse(11'h001 << REQ);
        chk_bit(req_ind, 1'b1);
        chk_bit(contingency_irq, 1'b1);
        end_test("request");
        // Clock enable low: a print and a clear in that cycle are both lost
        ce = 1'b0;
        print_data = 6'h31;
        pulse((11'h001 << PRT) | (11'h001 << CREQ));
        ce = 1'b1;
        chk_val(typewriter_char_buffer, 8'h15);
        chk_bit(req_ind, 1'b1);
        chk_bit(prt_valid, 1'b0);
        end_test("enable");
        results();
    end
endmodule : ctp_port_tb_top
